// file: common/mer_consts.svh
// register offsets, field positions and counts of the motion engine regs
`ifndef MER_CONSTS_SVH
`define MER_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define MER_IDX_STATUS 8'hF0
`define MER_IDX_WINCFG 8'hF2
`define MER_IDX_RATE_LO 8'hF3
`define MER_IDX_RATE_HI 8'hF4
`define MER_IDX_AVG 8'hF5
`define MER_IDX_DEBTIME 8'hF6
`define MER_IDX_BATCH 8'hF7
`define MER_IDX_TRSENS 8'hF8
`define MER_IDX_NSSENS 8'hF9
`define MER_IDX_SIG_LO 8'hFA
`define MER_IDX_SIG_HI 8'hFB
`define MER_IDX_DC_LO 8'hFC
`define MER_IDX_DC_HI 8'hFD

// status register bit positions
`define MER_ST_REFRESH 4
`define MER_ST_NEWSMP 3
`define MER_ST_ORIGIN 2
`define MER_ST_NOISE 1
`define MER_ST_TRANS 0

// window configuration field positions
`define MER_WC_LOCK_HI 7
`define MER_WC_LOCK_LO 5
`define MER_WC_SIZE_HI 4
`define MER_WC_SIZE_LO 3
`define MER_WC_RATE_HI 2
`define MER_WC_RATE_LO 0

// limit recompute period: base plus step times update rate, in samples
`define MER_LIM_BASE 5'h04
`define MER_LIM_STEP 5'h02

// sensitivity registers keep bit 7 reserved at zero
`define MER_SENS_MASK 8'h7F

`endif

// file: common/mer_pkg.sv
// types shared by the motion engine register bank
package mer_pkg;
  // control-limit window size selections
  typedef enum logic [1:0] {
    MER_WIN_RSVD = 2'h0,
    MER_WIN_SMALL = 2'h1,
    MER_WIN_MEDIUM = 2'h2,
    MER_WIN_LARGE = 2'h3
  } mer_win_t;

  // apb phase tracking, gray coded along idle, setup, access
  typedef enum logic [1:0] {
    MER_PH_IDLE = 2'h0,
    MER_PH_SETUP = 2'h1,
    MER_PH_ACCESS = 2'h3
  } mer_phase_t;
endpackage

// file: design/mer_regs.sv
// apb register bank and sample bookkeeping of the motion engine
//
// Functional notes
// - advanced registers get no initial value
// - refresh bit at init triggers fast buffer refill
// - new sample sets new sample flag
// - motion event updates origin flag, read only
// - noise found sets noise flag
// - transient found sets transient flag
// - lock level field bits seven to five
// - window size field: small, medium, large; zero reserved
// - update rate field zero to seven samples
// - limits recomputed every four plus twice rate
// - process rate sixteen bit read only
// - averaging count register sets sample averaging
// - debounce time register sets debounce duration
// - batch mask sets out-of-window samples needed
// - transient and noise sensitivity thresholds
// - current sensor sample readable, sixteen bits
// - current dc level readable, sixteen bits
`timescale 1ns/1ps
`include "mer_consts.svh"

module mer_regs
  import mer_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int SMP_W = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // engine side events and observations
  input wire logic engine_init_routine,
  input wire logic sample_valid,
  input wire logic [SMP_W-1:0] sample_value,
  input wire logic [SMP_W-1:0] dc_level,
  input wire logic [15:0] process_rate,
  input wire logic motion_event,
  input wire logic motion_extended,
  input wire logic noise_event,
  input wire logic transient_event,
  // configuration towards the engine
  output logic buffer_refill,
  output logic limit_update,
  output logic [2:0] lock_level,
  output mer_win_t window_size,
  output logic window_size_valid,
  output logic [2:0] update_rate,
  output logic [7:0] averaging_count,
  output logic [7:0] debounce_time,
  output logic [7:0] debounce_batch,
  output logic [6:0] transient_threshold,
  output logic [6:0] noise_threshold
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
    $error("address width must be 10 to 32 bits");
  end
  if (SMP_W < 1 || SMP_W > 16) begin : g_bad_smp
    $error("sample width must be 1 to 16 bits");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // index match: word aligned and index equal
  function automatic logic idx_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] idx);
    idx_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx});
  endfunction

  // limit period in samples for a given update rate
  function automatic logic [4:0] lim_period(input logic [2:0] r);
    lim_period = `MER_LIM_BASE + `MER_LIM_STEP * {2'h0, r};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register storage (no reset on software visible values)
  logic [7:0] status_flags; // flag bits 4..0 live here, top bits zero
  logic [7:0] win_cfg; // lock level, window size, update rate
  logic [7:0] avg_cnt; // sample averaging count
  logic [7:0] deb_time; // motion debounce time
  logic [7:0] deb_batch; // debounce batch mask
  logic [6:0] tr_sens; // transient sensitivity
  logic [6:0] ns_sens; // noise sensitivity
  logic [SMP_W-1:0] sig_hold; // last sensor sample
  logic [4:0] smp_cnt; // samples since last limit update
  mer_phase_t phase; // bus phase seen by this slave

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire setup_cyc = psel && !penable;
  // a write lands once, in the access cycle that follows its setup
  wire wr_take = psel && penable && pwrite && pready
                 && phase == MER_PH_SETUP;
  wire rd_setup = setup_cyc && !pwrite;
  wire hit_status = idx_hit(paddr, `MER_IDX_STATUS);
  wire hit_wincfg = idx_hit(paddr, `MER_IDX_WINCFG);
  wire hit_rate_lo = idx_hit(paddr, `MER_IDX_RATE_LO);
  wire hit_rate_hi = idx_hit(paddr, `MER_IDX_RATE_HI);
  wire hit_avg = idx_hit(paddr, `MER_IDX_AVG);
  wire hit_debtime = idx_hit(paddr, `MER_IDX_DEBTIME);
  wire hit_batch = idx_hit(paddr, `MER_IDX_BATCH);
  wire hit_trsens = idx_hit(paddr, `MER_IDX_TRSENS);
  wire hit_nssens = idx_hit(paddr, `MER_IDX_NSSENS);
  wire hit_sig_lo = idx_hit(paddr, `MER_IDX_SIG_LO);
  wire hit_sig_hi = idx_hit(paddr, `MER_IDX_SIG_HI);
  wire hit_dc_lo = idx_hit(paddr, `MER_IDX_DC_LO);
  wire hit_dc_hi = idx_hit(paddr, `MER_IDX_DC_HI);
  wire hit_ro = hit_rate_lo || hit_rate_hi || hit_sig_lo || hit_sig_hi
                || hit_dc_lo || hit_dc_hi;
  wire hit_rw = hit_status || hit_wincfg || hit_avg || hit_debtime
                || hit_batch || hit_trsens || hit_nssens;
  wire hit_any = hit_ro || hit_rw;
  // only the low byte lane carries register write data
  wire lane0 = pstrb[0];
  wire wr_en = wr_take && lane0;

  // zero extended 16-bit observation values
  wire [15:0] sig16 = {{(16-SMP_W){1'b0}}, sig_hold};
  wire [15:0] dc16 = {{(16-SMP_W){1'b0}}, dc_level};

  // read data mux, low byte or full half-word at the low index
  wire [31:0] rd_mux =
      hit_status ? {24'h0, status_flags} :
      hit_wincfg ? {24'h0, win_cfg} :
      hit_rate_lo ? {16'h0, process_rate} :
      hit_rate_hi ? {24'h0, process_rate[15:8]} :
      hit_avg ? {24'h0, avg_cnt} :
      hit_debtime ? {24'h0, deb_time} :
      hit_batch ? {24'h0, deb_batch} :
      hit_trsens ? {25'h0, tr_sens} :
      hit_nssens ? {25'h0, ns_sens} :
      hit_sig_lo ? {16'h0, sig16} :
      hit_sig_hi ? {24'h0, sig16[15:8]} :
      hit_dc_lo ? {16'h0, dc16} :
      hit_dc_hi ? {24'h0, dc16[15:8]} :
      32'h0;

  ////////////////////////////////////////////////////////////////////////
  // status flag next values: hardware set wins over software write
  wire wr_status = wr_en && hit_status;
  wire [7:0] wv = pwdata[7:0];
  wire next_refresh = wr_status ? wv[`MER_ST_REFRESH]
                                : status_flags[`MER_ST_REFRESH];
  wire next_newsmp = sample_valid ||
      (wr_status ? wv[`MER_ST_NEWSMP] : status_flags[`MER_ST_NEWSMP]);
  wire next_origin = motion_event ? motion_extended
                                  : status_flags[`MER_ST_ORIGIN];
  wire next_noise = noise_event ||
      (wr_status ? wv[`MER_ST_NOISE] : status_flags[`MER_ST_NOISE]);
  wire next_trans = transient_event ||
      (wr_status ? wv[`MER_ST_TRANS] : status_flags[`MER_ST_TRANS]);

  ////////////////////////////////////////////////////////////////////////
  // limit update timing
  wire [4:0] period = lim_period(update_rate);
  wire period_end = sample_valid && (smp_cnt >= period - 5'h01);
  wire refill_now = engine_init_routine && status_flags[`MER_ST_REFRESH];
  wire [4:0] next_smp_cnt = (refill_now || period_end) ? 5'h00
                          : sample_valid ? smp_cnt + 5'h01 : smp_cnt;

  ////////////////////////////////////////////////////////////////////////
  // software visible registers, deliberately not reset
  always_ff @(posedge mclk) begin
    status_flags <= {3'h0, next_refresh, next_newsmp, next_origin,
                     next_noise, next_trans};
    if (wr_en && hit_wincfg) begin
      win_cfg <= pwdata[7:0];
    end
    if (wr_en && hit_avg) begin
      avg_cnt <= pwdata[7:0];
    end
    if (wr_en && hit_debtime) begin
      deb_time <= pwdata[7:0];
    end
    if (wr_en && hit_batch) begin
      deb_batch <= pwdata[7:0];
    end
    if (wr_en && hit_trsens) begin
      tr_sens <= pwdata[6:0];
    end
    if (wr_en && hit_nssens) begin
      ns_sens <= pwdata[6:0];
    end
  end

  // sample capture from the engine
  always_ff @(posedge mclk) begin
    if (sample_valid) begin
      sig_hold <= sample_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control state with reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      smp_cnt <= 5'h00;
      buffer_refill <= 1'b0;
      limit_update <= 1'b0;
    end else begin
      smp_cnt <= next_smp_cnt;
      buffer_refill <= refill_now;
      limit_update <= period_end && !refill_now;
    end
  end

  // bus phase tracking
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase <= MER_PH_IDLE;
    end else begin
      case (phase)
        MER_PH_IDLE: begin
          phase <= setup_cyc ? MER_PH_SETUP : MER_PH_IDLE;
        end
        MER_PH_SETUP: begin
          phase <= MER_PH_ACCESS;
        end
        MER_PH_ACCESS: begin
          phase <= setup_cyc ? MER_PH_SETUP : MER_PH_IDLE;
        end
        default: begin
          phase <= MER_PH_IDLE;
        end
      endcase
    end
  end

  // read data and error captured in the setup cycle, shown in access
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup_cyc) begin
      prdata <= rd_setup ? rd_mux : 32'h0;
      pslverr <= !hit_any || (pwrite && hit_ro);
    end
  end

  // every access completes in its first access cycle
  assign pready = psel && penable;

  ////////////////////////////////////////////////////////////////////////
  // outputs towards the engine
  assign lock_level = win_cfg[`MER_WC_LOCK_HI:`MER_WC_LOCK_LO];
  assign window_size =
      mer_win_t'(win_cfg[`MER_WC_SIZE_HI:`MER_WC_SIZE_LO]);
  assign window_size_valid = window_size != MER_WIN_RSVD;
  assign update_rate = win_cfg[`MER_WC_RATE_HI:`MER_WC_RATE_LO];
  assign averaging_count = avg_cnt;
  assign debounce_time = deb_time;
  assign debounce_batch = deb_batch;
  assign transient_threshold = tr_sens;
  assign noise_threshold = ns_sens;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  // the flags have no reset value: checks across cycles wait for them
  logic flags_known; // a status write has defined the software flags
  logic origin_known; // a motion event has defined the origin flag

  // helper state follows reset, unlike the flags that it guards
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flags_known <= 1'b0;
      origin_known <= 1'b0;
    end else begin
      flags_known <= flags_known || wr_status;
      origin_known <= origin_known || motion_event;
    end
  end

  // init routine runs while the refresh bit is set
  sequence s_init_refresh;
    engine_init_routine && status_flags[`MER_ST_REFRESH];
  endsequence

  // refill strobe high for exactly one cycle
  sequence s_refill_pulse;
    buffer_refill ##1 !buffer_refill;
  endsequence

  // status write that clears both event flags
  sequence s_event_clear;
    wr_status && !wv[`MER_ST_NOISE] && !wv[`MER_ST_TRANS];
  endsequence

  // refill strobe
  a_refill_on_init: assert property (
    @(posedge mclk) disable iff (sys_rst)
    s_init_refresh ##1 !engine_init_routine |-> s_refill_pulse)
    else $error("refill pulse missing or too long after init");

  a_refill_cause: assert property (
    @(posedge mclk) disable iff (sys_rst)
    buffer_refill |-> $past(engine_init_routine))
    else $error("refill pulse without init routine");

  // sample and origin flags
  a_newsmp_set: assert property (
    @(posedge mclk) disable iff (sys_rst)
    sample_valid |=> status_flags[`MER_ST_NEWSMP]
                     && sig_hold == $past(sample_value))
    else $error("new sample flag or data not updated");

  a_newsmp_hold: assert property (
    @(posedge mclk) disable iff (sys_rst)
    flags_known && !sample_valid && !wr_status
    |=> $stable(status_flags[`MER_ST_NEWSMP]))
    else $error("new sample flag moved without sample or write");

  a_origin_track: assert property (
    @(posedge mclk) disable iff (sys_rst)
    motion_event |=> status_flags[`MER_ST_ORIGIN]
                     == $past(motion_extended))
    else $error("origin flag does not match detector");

  a_origin_hold: assert property (
    @(posedge mclk) disable iff (sys_rst)
    origin_known && !motion_event |=> $stable(status_flags[`MER_ST_ORIGIN]))
    else $error("origin flag changed without motion event");

  // event flags stick until software clears them
  a_noise_sticky: assert property (
    @(posedge mclk) disable iff (sys_rst)
    flags_known && status_flags[`MER_ST_NOISE] && !wr_status
    |=> status_flags[`MER_ST_NOISE])
    else $error("noise flag dropped without software clear");

  a_trans_sticky: assert property (
    @(posedge mclk) disable iff (sys_rst)
    flags_known && status_flags[`MER_ST_TRANS] && !wr_status
    |=> status_flags[`MER_ST_TRANS])
    else $error("transient flag dropped without software clear");

  a_set_beats_clr: assert property (
    @(posedge mclk) disable iff (sys_rst)
    s_event_clear ##0 (noise_event || transient_event)
    |=> status_flags[`MER_ST_NOISE] == $past(noise_event)
        && status_flags[`MER_ST_TRANS] == $past(transient_event))
    else $error("event lost against software clear");

  // configuration and limit timing
  a_cfg_write: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_en && hit_wincfg
    |=> {lock_level, window_size, update_rate} == $past(wv))
    else $error("window configuration write not applied");

  a_limit_period: assert property (
    @(posedge mclk) disable iff (sys_rst)
    limit_update |-> smp_cnt == 5'h00 && $past(smp_cnt) == period - 5'h01)
    else $error("limit update at wrong sample count");

  a_limit_min_gap: assert property (
    @(posedge mclk) disable iff (sys_rst)
    limit_update |=> !limit_update [*3])
    else $error("limit updates closer than four samples apart");

  // bus answers
  a_ro_write_err: assert property (
    @(posedge mclk) disable iff (sys_rst)
    setup_cyc && pwrite && hit_ro |=> pready && pslverr)
    else $error("write to read-only register not flagged");

  a_rate_read: assert property (
    @(posedge mclk) disable iff (sys_rst)
    setup_cyc && !pwrite && hit_rate_lo
    |=> prdata == {16'h0, $past(process_rate)})
    else $error("process rate read mismatch");

endmodule

// file: sim/test_motion_engine_advanced_regs.sv
// self-checking bench for the motion engine advanced register bank
`timescale 1ns/1ps
`include "mer_consts.svh"

// compare a design value against the expected one and count it
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module test_motion_engine_advanced_regs
  import mer_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  // signals
  logic mclk, sys_rst, psel, penable, pwrite; // clock, reset, apb control
  logic [11:0] paddr; // apb byte address
  logic [31:0] pwdata, prdata; // apb data
  logic [3:0] pstrb; // apb byte strobes
  logic pready, pslverr; // apb answer
  logic engine_init, sample_valid, motion_event; // engine pulses
  logic motion_extended, noise_event, transient_event;
  logic [15:0] sample_value, dc_level, process_rate; // engine observations
  logic buffer_refill, limit_update, window_size_valid;
  logic [2:0] lock_level, update_rate;
  mer_win_t window_size;
  logic [7:0] averaging_count, debounce_time, debounce_batch;
  logic [6:0] transient_threshold, noise_threshold;
  logic [31:0] rd_data; // data of the last apb transfer
  logic rd_err; // error of the last apb transfer
  logic [7:0] v; // random register value
  int num_errors = 0;
  int tests_run = 0;

  ////////////////////////////////////////////////////////////////////////////
  // design under test
  mer_regs i_mer_regs (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .engine_init_routine(engine_init), .sample_valid(sample_valid),
    .sample_value(sample_value), .dc_level(dc_level),
    .process_rate(process_rate), .motion_event(motion_event),
    .motion_extended(motion_extended), .noise_event(noise_event),
    .transient_event(transient_event), .buffer_refill(buffer_refill),
    .limit_update(limit_update), .lock_level(lock_level),
    .window_size(window_size), .window_size_valid(window_size_valid),
    .update_rate(update_rate), .averaging_count(averaging_count),
    .debounce_time(debounce_time), .debounce_batch(debounce_batch),
    .transient_threshold(transient_threshold),
    .noise_threshold(noise_threshold));

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d, input logic [3:0] st);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    pstrb <= st;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // a slave that never answers ends the run
    if (pready !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED pready exp 1 got 0");
      stop_test();
    end
  endtask

  // one-cycle engine pulse, then let the taking edge settle
  task automatic ev(input int k);
    @(posedge mclk);
    case (k)
      0: engine_init <= 1'b1;
      1: sample_valid <= 1'b1;
      2: motion_event <= 1'b1;
      3: noise_event <= 1'b1;
      default: transient_event <= 1'b1;
    endcase
    @(posedge mclk);
    {engine_init, sample_valid, motion_event} <= 3'h0;
    {noise_event, transient_event} <= 2'h0;
    #1;
  endtask

  // limit recompute expected after the k-th sample at update rate r
  function automatic logic exp_lim(input int k, input int r);
    return (k % (4 + 2 * r)) == 0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {engine_init, sample_valid, motion_event, motion_extended} = 4'h0;
    {noise_event, transient_event} = 2'h0;
    {sample_value, dc_level, process_rate} = '0;
    sys_rst = 1'b1;
    void'($urandom(43443));
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    `CHK("rst_prdata", 32'h0, prdata)
    `CHK("rst_refill", 1'b0, buffer_refill)
    `CHK("rst_limit", 1'b0, limit_update)
    $display("test reset done");
    // configuration fields, every window code among random values
    for (int i = 0; i < 12; i++) begin
      v = 8'($urandom);
      v[4:3] = 2'(i);
      apb(1'b1, `MER_IDX_WINCFG, v, 4'hF);
      apb(1'b0, `MER_IDX_WINCFG, 8'h00, 4'h0);
      `CHK("wincfg", v, rd_data[7:0])
      `CHK("lock", v[7:5], lock_level)
      `CHK("wsize", v[4:3], 2'(window_size))
      `CHK("wvalid", v[4:3] != 2'h0, window_size_valid)
      `CHK("urate", v[2:0], update_rate)
      for (int a = `MER_IDX_AVG; a <= `MER_IDX_NSSENS; a++) begin
        apb(1'b1, 8'(a), v ^ 8'(a), 4'hF);
        apb(1'b0, 8'(a), 8'h00, 4'h0);
        `CHK("tune", (a >= `MER_IDX_TRSENS) ? (v ^ 8'(a)) & `MER_SENS_MASK
             : v ^ 8'(a), rd_data[7:0])
      end
      `CHK("avg", v ^ `MER_IDX_AVG, averaging_count)
      `CHK("deb", v ^ `MER_IDX_DEBTIME, debounce_time)
      `CHK("batch", v ^ `MER_IDX_BATCH, debounce_batch)
      `CHK("trs", 7'(v ^ `MER_IDX_TRSENS), transient_threshold)
      `CHK("nss", 7'(v ^ `MER_IDX_NSSENS), noise_threshold)
    end
    // write without the low byte strobe leaves the register alone
    apb(1'b1, `MER_IDX_AVG, ~averaging_count, 4'hE);
    `CHK("strb_err", 1'b0, rd_err)
    `CHK("strb_keep", v ^ `MER_IDX_AVG, averaging_count)
    $display("test config done");
    // read-only values, a refused write and an unmapped index
    process_rate <= 16'($urandom);
    dc_level <= 16'($urandom);
    apb(1'b0, `MER_IDX_RATE_LO, 8'h00, 4'h0);
    `CHK("rate", process_rate, rd_data[15:0])
    apb(1'b0, `MER_IDX_RATE_HI, 8'h00, 4'h0);
    `CHK("rate_hi", process_rate[15:8], rd_data[7:0])
    apb(1'b0, `MER_IDX_DC_LO, 8'h00, 4'h0);
    `CHK("dc", dc_level, rd_data[15:0])
    apb(1'b0, `MER_IDX_DC_HI, 8'h00, 4'h0);
    `CHK("dc_hi", dc_level[15:8], rd_data[7:0])
    apb(1'b1, `MER_IDX_RATE_LO, 8'h5A, 4'hF);
    `CHK("ro_err", 1'b1, rd_err)
    apb(1'b0, 8'hF1, 8'h00, 4'h0);
    `CHK("unmap_err", 1'b1, rd_err)
    `CHK("unmap_data", 32'h0, rd_data)
    $display("test readonly done");
    // new sample flag, sample value, software clear
    apb(1'b1, `MER_IDX_STATUS, 8'h00, 4'hF);
    sample_value <= 16'($urandom);
    ev(1);
    apb(1'b0, `MER_IDX_STATUS, 8'h00, 4'h0);
    `CHK("newsmp", 1'b1, rd_data[`MER_ST_NEWSMP])
    apb(1'b0, `MER_IDX_SIG_LO, 8'h00, 4'h0);
    `CHK("sample", sample_value, rd_data[15:0])
    apb(1'b0, `MER_IDX_SIG_HI, 8'h00, 4'h0);
    `CHK("sample_hi", sample_value[15:8], rd_data[7:0])
    apb(1'b1, `MER_IDX_STATUS, 8'h00, 4'hF);
    apb(1'b0, `MER_IDX_STATUS, 8'h00, 4'h0);
    `CHK("newsmp_clr", 1'b0, rd_data[`MER_ST_NEWSMP])
    // origin follows the detector; software cannot write it
    for (int e = 1; e >= 0; e--) begin
      motion_extended <= 1'(e);
      ev(2);
      apb(1'b1, `MER_IDX_STATUS, 8'(e == 0) << `MER_ST_ORIGIN, 4'hF);
      apb(1'b0, `MER_IDX_STATUS, 8'h00, 4'h0);
      `CHK("origin", 1'(e), rd_data[`MER_ST_ORIGIN])
    end
    // noise and transient flags stick until cleared
    ev(3);
    ev(4);
    apb(1'b0, `MER_IDX_STATUS, 8'h00, 4'h0);
    `CHK("noise", 1'b1, rd_data[`MER_ST_NOISE])
    `CHK("trans", 1'b1, rd_data[`MER_ST_TRANS])
    apb(1'b1, `MER_IDX_STATUS, 8'h00, 4'hF);
    apb(1'b0, `MER_IDX_STATUS, 8'h00, 4'h0);
    `CHK("ev_clr", 2'h0, rd_data[1:0])
    // noise event on the very edge of a clearing write: the set wins
    fork
      apb(1'b1, `MER_IDX_STATUS, 8'h00, 4'hF);
      begin
        repeat (2) @(posedge mclk);
        noise_event <= 1'b1;
        @(posedge mclk);
        noise_event <= 1'b0;
      end
    join
    apb(1'b0, `MER_IDX_STATUS, 8'h00, 4'h0);
    `CHK("set_wins", 1'b1, rd_data[`MER_ST_NOISE])
    $display("test flags done");
    // refill pulse only when the refresh bit is set at init
    apb(1'b1, `MER_IDX_STATUS, 8'h10, 4'hF);
    ev(0);
    `CHK("refill", 1'b1, buffer_refill)
    @(posedge mclk);
    #1;
    `CHK("refill_end", 1'b0, buffer_refill)
    apb(1'b1, `MER_IDX_STATUS, 8'h00, 4'hF);
    ev(0);
    `CHK("no_refill", 1'b0, buffer_refill)
    $display("test refill done");
    // limit recompute period for update rates 0, 3 and 6
    for (int r = 0; r < 8; r += 3) begin
      apb(1'b1, `MER_IDX_WINCFG, {3'h2, 2'h1, 3'(r)}, 4'hF);
      apb(1'b1, `MER_IDX_STATUS, 8'h10, 4'hF);
      ev(0);
      apb(1'b1, `MER_IDX_STATUS, 8'h00, 4'hF);
      for (int k = 1; k <= 2 * (4 + 2 * r); k++) begin
        sample_value <= 16'($urandom);
        ev(1);
        `CHK("limit", exp_lim(k, r), limit_update)
      end
    end
    $display("test limits done");
    stop_test();
  end
endmodule
